// *** core/spi_eeprom_pkg.sv ***
// Constants, codes and types shared by the serial memory command slave
package spi_eeprom_pkg;

   // Instruction codes
   localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
   localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] STATUS_PROGRAM_CMD = 8'h01;
   localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
   localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;
   localparam logic [7:0] OPCODE_MASK = 8'hF7;
   localparam int ADDR_MSB_POS = 3;

   // Geometry
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int WORD_W = ADDR_W + DATA_W;
   localparam int FIFO_DEPTH = 8;

   // Status layout
   localparam int BUSY_POS = 0;
   localparam int WRITE_LATCH_POS = 1;
   localparam int PROTECT_LEVEL_BIT_LO = 2;
   localparam int PROTECT_LEVEL_BIT_HI = 3;
   localparam logic [7:0] STATUS_BUSY_VALUE = 8'hFF;
   localparam logic [3:0] STATUS_UNUSED_VALUE = 4'h0;
   localparam logic [1:0] PROTECT_RESET = 2'h0;

   // Self-timed programming cycle
   localparam int PROG_TIME_US = 15000;
   localparam int CLK_MHZ = 200;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

   // Serial sequence phases, Gray coded along the usual path
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_OPCODE = 3'b001,
      PH_ADDR = 3'b011,
      PH_READ = 3'b010,
      PH_WRITE = 3'b110,
      PH_STATUS = 3'b111,
      PH_SPROG = 3'b101,
      PH_IGNORE = 3'b100
   } phase_e;

endpackage : spi_eeprom_pkg

// *** core/spi_eeprom_slave.sv ***
// Serial command slave of a 512-byte nonvolatile memory
`timescale 1ns/1ps
module spi_eeprom_slave #(
   parameter int PROG_COUNT = spi_eeprom_pkg::PROG_CYCLES,
   parameter int DEPTH = spi_eeprom_pkg::FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic hold_n,
   output logic so,
   output logic so_oe,
   output logic [spi_eeprom_pkg::ADDR_W-1:0] mem_rd_addr,
   input wire logic [spi_eeprom_pkg::DATA_W-1:0] mem_rd_data,
   output logic mem_wr_valid,
   input wire logic mem_wr_ready,
   output logic [spi_eeprom_pkg::ADDR_W-1:0] mem_wr_addr,
   output logic [spi_eeprom_pkg::DATA_W-1:0] mem_wr_data,
   output logic [1:0] protect_level,
   output logic busy
);
   import spi_eeprom_pkg::*;

   // How the block works, in brief
   //
   // Every pin is sampled on mclk. The serial clock is never driven here;
   // its edges are found by comparing each sample with the one before.
   // Because of that the serial clock must stay high and low for at least
   // one mclk period, or an edge can slip between two samples unseen.
   //
   // A frame starts when select falls. The first eight rising edges build
   // the instruction byte. Its decode picks one of these paths:
   //   - Latch set or clear: acts at the end of the byte, rest ignored.
   //   - Status read: the status byte goes out again and again.
   //   - Status program: one data byte, applied when select rises.
   //   - Array read: low address byte, then data with a running address.
   //   - Array write: low address byte, then data bytes into the queue.
   //   - Anything else: the rest of the frame is ignored.
   //
   // Data leave on the falling edge seen after a byte boundary. The first
   // bit of each byte is loaded from the array port or the status value,
   // the next seven come from a shift register.
   //
   // Written bytes do not reach the array directly. They pass through a
   // small queue, so a slow array port never stalls the serial side. The
   // price is that a full queue drops bytes; the master sees this only as
   // a longer busy time or missing data, never as an error on the link.
   //
   // The programming cycle is a plain down counter that starts when select
   // rises after a frame that queued data or a new protection level. Busy
   // stays up until the counter ends and the queue has drained, so the
   // master never starts a new write into a queue still in use.
   //
   // Hold freezes the edge finder only. Every sequence register keeps its value, so
   // the sequence picks up at the same bit when hold is released. The pin
   // is released during hold so that another device may use the line.
   //
   // Limitations a user must know:
   //   - The protection level is kept in flip-flops and reset to zero.
   //   - A partial byte at the end of a frame is thrown away.
   //   - The array port must answer a read address before the next fall.

   localparam int CW = $clog2(PROG_COUNT + 1);

   // Whole state of the command slave
   typedef struct packed {
      phase_e phase;             // Serial sequence position
      logic sck_q;               // Previous clock sample for edge finding
      logic cs_q;                // Previous select sample
      logic [2:0] bit_cnt;       // Bits of the current byte taken
      logic [7:0] shin;          // Incoming byte
      logic [7:0] shout;         // Outgoing bits still to send
      logic load_pend;           // Next falling edge starts a new byte
      logic drive;               // Output has begun in this frame
      logic is_write;            // Address phase belongs to a write
      logic [ADDR_W-1:0] addr;   // Working array address
      logic wel;                 // Write-enable latch
      logic [1:0] prot;          // Protection level in force
      logic [1:0] prot_new;      // Level waiting for its programming cycle
      logic prog_pend;           // Data bytes queued, cycle starts on deselect
      logic sprog_pend;          // Status byte taken, cycle starts on deselect
      logic [CW-1:0] prog_cnt;   // Remaining programming time
      logic so;
      logic so_oe;
      logic [ADDR_W-1:0] rd_addr;
      logic push;                // One-cycle enqueue toward the array
      logic [WORD_W-1:0] push_word;
      logic busy;
   } slave_s;

   slave_s s;
   slave_s n;

   logic fifo_ready;
   logic fifo_empty;
   logic rise;
   logic fall;
   logic cs_rise;
   logic cs_fall;
   logic busy_now;
   logic [7:0] byte_in;
   logic [7:0] out_byte;

   // Protected range check for each level
   // Only the top two address bits matter, since every range starts on a
   // quarter or a half boundary and runs up to the last byte.
   function automatic logic is_protected(input logic [1:0] level,
                                         input logic [ADDR_W-1:0] a);
      case (level)
         2'd0: is_protected = 1'b0;
         2'd1: is_protected = (a[8:7] == 2'b11);   // 180-1FF
         2'd2: is_protected = a[8];                // 100-1FF
         default: is_protected = 1'b1;             // Whole array
      endcase
   endfunction : is_protected

   // Status byte as seen by the master
   function automatic logic [7:0] status_value(input logic bsy, input logic latch,
                                               input logic [1:0] level);
      if (bsy) begin
         status_value = STATUS_BUSY_VALUE;
      end else begin
         status_value = {STATUS_UNUSED_VALUE, level, latch, 1'b0};
      end
   endfunction : status_value

   // Sequencer, latch, protection and programming timer
   // One process holds every decision, so that the order of priority is
   // plain to read: deselect first, then the start of a frame, then a
   // rising edge, and a falling edge last. A rising and a falling edge
   // can never be seen in one cycle, so that order loses nothing.
   // The timer runs outside that chain: it must count down whether or not
   // the master is talking, otherwise a long frame would stretch the cycle.
   always_comb begin
      n = s;
      n.push = 1'b0;
      n.sck_q = sck;
      n.cs_q = cs_n;
      byte_in = {s.shin[6:0], si};
      out_byte = 8'h00;
      // Clock is only ever sampled; edges count only when selected and not held
      rise = sck && !s.sck_q && !cs_n && hold_n;
      fall = !sck && s.sck_q && !cs_n && hold_n;
      cs_rise = cs_n && !s.cs_q;
      cs_fall = !cs_n && s.cs_q;
      busy_now = (s.prog_cnt != '0) || !fifo_empty;

      // Timer runs down; latch drops when the cycle ends
      if (s.prog_cnt != '0) begin
         n.prog_cnt = s.prog_cnt - 1'b1;
         if (s.prog_cnt == CW'(1)) begin
            n.wel = 1'b0;
         end
      end

      if (cs_n) begin
         // Deselected: nothing is taken and the pin is released
         n.phase = PH_IDLE;
         n.drive = 1'b0;
         n.load_pend = 1'b0;
         if (cs_rise && (s.prog_pend || s.sprog_pend)) begin
            n.prog_cnt = CW'(PROG_COUNT);
            if (s.sprog_pend) begin
               n.prot = s.prot_new;
            end
            n.prog_pend = 1'b0;
            n.sprog_pend = 1'b0;
         end
      end else if (cs_fall) begin
         // Fresh frame always starts with an opcode
         n.phase = PH_OPCODE;
         n.bit_cnt = 3'd0;
         n.drive = 1'b0;
         n.load_pend = 1'b0;
      end else if (rise && (s.phase != PH_IGNORE)) begin
         n.shin = byte_in;
         n.bit_cnt = s.bit_cnt + 3'd1;
         if (s.bit_cnt == 3'd7) begin
            case (s.phase)
               PH_OPCODE: begin
                  if (busy_now && (byte_in != STATUS_READ_CMD)) begin
                     n.phase = PH_IGNORE;
                  end else if (byte_in == SET_WRITE_LATCH_CMD) begin
                     n.wel = 1'b1;
                     n.phase = PH_IGNORE;
                  end else if (byte_in == CLEAR_WRITE_LATCH_CMD) begin
                     n.wel = 1'b0;
                     n.phase = PH_IGNORE;
                  end else if (byte_in == STATUS_READ_CMD) begin
                     n.phase = PH_STATUS;
                     n.load_pend = 1'b1;
                  end else if (byte_in == STATUS_PROGRAM_CMD) begin
                     // Without the latch the instruction is dropped
                     n.phase = s.wel ? PH_SPROG : PH_IGNORE;
                  end else if ((byte_in & OPCODE_MASK) == ARRAY_READ_CMD) begin
                     n.addr[ADDR_W-1] = byte_in[ADDR_MSB_POS];
                     n.is_write = 1'b0;
                     n.phase = PH_ADDR;
                  end else if ((byte_in & OPCODE_MASK) == ARRAY_WRITE_CMD) begin
                     n.addr[ADDR_W-1] = byte_in[ADDR_MSB_POS];
                     n.is_write = 1'b1;
                     n.phase = s.wel ? PH_ADDR : PH_IGNORE;
                  end else begin
                     n.phase = PH_IGNORE;
                  end
               end
               PH_ADDR: begin
                  n.addr[7:0] = byte_in;
                  if (s.is_write) begin
                     n.phase = PH_WRITE;
                  end else begin
                     // Input is don't care from here; data goes out
                     n.phase = PH_READ;
                     n.rd_addr = {s.addr[ADDR_W-1], byte_in};
                     n.load_pend = 1'b1;
                  end
               end
               PH_WRITE: begin
                  // Protected bytes are dropped, so no cycle starts for them
                  if (!is_protected(s.prot, s.addr) && fifo_ready) begin
                     n.push = 1'b1;
                     n.push_word = {s.addr, byte_in};
                     n.prog_pend = 1'b1;
                  end
                  // Only the two low bits move: extra bytes roll over the page
                  n.addr[1:0] = s.addr[1:0] + 2'd1;
               end
               PH_SPROG: begin
                  n.prot_new = byte_in[PROTECT_LEVEL_BIT_HI:PROTECT_LEVEL_BIT_LO];
                  n.sprog_pend = 1'b1;
                  n.phase = PH_IGNORE;
               end
               PH_READ: begin
                  // Nine-bit add wraps 1FF to 000 on its own
                  n.addr = s.addr + 1'b1;
                  n.rd_addr = s.addr + 1'b1;
                  n.load_pend = 1'b1;
               end
               PH_STATUS: begin
                  n.load_pend = 1'b1;
               end
               default: begin
                  n.phase = PH_IGNORE;
               end
            endcase
         end
      end else if (fall && ((s.phase == PH_READ) || (s.phase == PH_STATUS))) begin
         // Output changes only on the falling edge, MSB first
         if (s.load_pend) begin
            if (s.phase == PH_READ) begin
               out_byte = mem_rd_data;
            end else begin
               out_byte = status_value(busy_now, s.wel, s.prot);
            end
            n.so = out_byte[7];
            n.shout = {out_byte[6:0], 1'b0};
            n.load_pend = 1'b0;
            n.drive = 1'b1;
         end else begin
            n.so = s.shout[7];
            n.shout = {s.shout[6:0], 1'b0};
         end
      end

      // Pin is released while deselected, held, or not sending
      n.so_oe = !cs_n && hold_n && n.drive &&
                ((n.phase == PH_READ) || (n.phase == PH_STATUS));
      n.busy = (n.prog_cnt != '0) || !fifo_empty || n.push;
   end

   // State register
   // Reset clears everything; the previous select sample starts high, so
   // that a select held low through reset is taken as a fall in the first
   // cycle and starts a frame at once. The clock sample starts low, its idle
   // level, which keeps a false falling edge from following reset.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
         s.phase <= PH_IDLE;
         s.sck_q <= 1'b0;
         s.cs_q <= 1'b1;
         s.wel <= 1'b0;
         s.prot <= PROTECT_RESET;
      end else begin
         s <= n;
      end
   end

   // Queue between the serial side and the array write port
   // Each entry is the full nine-bit address and the data byte, so the
   // array port needs no state of its own. The queue is sized so that a
   // page of data and more fit while the array is stalled; a push is only
   // made when the queue shows room, so no byte is lost inside it.
   write_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .nrst(nrst),
      .in_valid(s.push),
      .in_ready(fifo_ready),
      .in_data(s.push_word),
      .out_valid(mem_wr_valid),
      .out_ready(mem_wr_ready),
      .out_data({mem_wr_addr, mem_wr_data}),
      .empty(fifo_empty)
   );

   // Outputs come straight from the state register; nothing is decoded on
   // the way out, so the pins never glitch between clock edges.
   assign so = s.so;
   assign so_oe = s.so_oe;
   assign mem_rd_addr = s.rd_addr;
   assign protect_level = s.prot;
   assign busy = s.busy;

endmodule : spi_eeprom_slave

// *** core/write_fifo.sv ***
// Parameterised FIFO with a registered output stage
`timescale 1ns/1ps
module write_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic empty
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Whole state of the queue
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
      logic ov;
      logic [WIDTH-1:0] od;
   } fifo_s;

   fifo_s s;
   fifo_s n;
   logic push;
   logic pop;

   // Output stage: refill when empty or being taken
   always_comb begin
      n = s;
      // The output register holds a word too, so it counts toward the depth
      push = in_valid && ((s.count + (AW + 1)'(s.ov)) != (AW + 1)'(DEPTH));
      pop = (s.count != '0) && (!s.ov || out_ready);
      if (push) begin
         n.mem[s.wr_ptr] = in_data;
         n.wr_ptr = (s.wr_ptr == AW'(DEPTH - 1)) ? '0 : s.wr_ptr + 1'b1;
      end
      if (pop) begin
         n.od = s.mem[s.rd_ptr];
         n.ov = 1'b1;
         n.rd_ptr = (s.rd_ptr == AW'(DEPTH - 1)) ? '0 : s.rd_ptr + 1'b1;
      end else if (out_ready) begin
         n.ov = 1'b0;
      end
      // Count changes only when exactly one side moves
      if (push && !pop) begin
         n.count = s.count + 1'b1;
      end else if (pop && !push) begin
         n.count = s.count - 1'b1;
      end
   end

   // State register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Full is honest: ready drops at DEPTH words, output stage included
   assign in_ready = ((s.count + (AW + 1)'(s.ov)) != (AW + 1)'(DEPTH));
   assign out_valid = s.ov;
   assign out_data = s.od;
   assign empty = (s.count == '0) && !s.ov;

endmodule : write_fifo

// *** tb/spi_eeprom_slave_chk.sv ***
// Port checker of the serial memory command slave
`timescale 1ns/1ps
module spi_eeprom_slave_chk
   import spi_eeprom_pkg::*;
#(
   parameter int PROG_COUNT = 50
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic hold_n,
   input wire logic so,
   input wire logic so_oe,
   input wire logic mem_wr_valid,
   input wire logic [spi_eeprom_pkg::ADDR_W-1:0] mem_wr_addr,
   input wire logic [1:0] protect_level,
   input wire logic busy
);
   int busy_run; // Edges for which busy has been high
   logic [ADDR_W-1:0] last_wr_addr; // Word address one cycle back
   // Helper registers; a counter avoids unrolling a long repetition
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         busy_run <= 0;
         last_wr_addr <= '0;
      end else begin
         busy_run <= busy ? busy_run + 1 : 0;
         last_wr_addr <= mem_wr_addr;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   a_desel_quiet: assert property (cs_n [*3] |-> !so_oe)
      else $error("serial output enabled while deselected");
   a_hold_quiet: assert property (!hold_n [*3] |-> !so_oe)
      else $error("serial output enabled during hold");
   a_out_on_fall: assert property (
      so_oe && $past(so_oe) && so != $past(so) |-> !$past(sck) && ($past(sck, 2) || $past(sck, 3)))
      else $error("serial output moved without a clock fall");
   a_wr_protect: assert property (mem_wr_valid |-> !(protect_level == 2'h3 ||
      (protect_level == 2'h2 && mem_wr_addr[8]) || (protect_level == 2'h1 && &mem_wr_addr[8:7])))
      else $error("write issued inside the protected range");
   a_page_fixed: assert property (mem_wr_valid && $past(mem_wr_valid) |->
      mem_wr_addr[8:2] == last_wr_addr[8:2])
      else $error("page write left its page");
   a_busy_length: assert property ($fell(busy) && cs_n |-> busy_run >= PROG_COUNT - 1)
      else $error("programming cycle too short");
   a_level_desel: assert property ($changed(protect_level) |-> cs_n)
      else $error("protection level changed while selected");
   a_busy_ones: assert property (busy && $past(busy) && so_oe |-> so)
      else $error("status during programming not all ones");
endmodule : spi_eeprom_slave_chk

bind spi_eeprom_slave spi_eeprom_slave_chk #(.PROG_COUNT(PROG_COUNT)) u_chk (
   .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .hold_n(hold_n), .so(so),
   .so_oe(so_oe), .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr),
   .protect_level(protect_level), .busy(busy)
);

// *** tb/spi_eeprom_slave_test.sv ***
// Self-checking bench of the serial memory command slave
`timescale 1ns/1ps
module spi_eeprom_slave_test;
   import spi_eeprom_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic mem_wr_ready = 1'b0;
   logic cs_n, sck, si, hold_n, so, so_oe, mem_wr_valid, busy;
   logic [ADDR_W-1:0] mem_rd_addr, mem_wr_addr;
   logic [DATA_W-1:0] mem_rd_data, mem_wr_data;
   logic [1:0] protect_level;
   logic [7:0] txq[$], rxq[$];
   logic [WORD_W-1:0] got[$], exp_q[$];
   logic [8:0] prot_addr[3] = '{9'h0FF, 9'h17F, 9'h180}; // Edges of the protected ranges
   int n_mismatch = 0;
   int samples_checked = 0;
   always #2.5 mclk = ~mclk;
   // Array stand-in: data is a scramble of the address, given at once
   assign mem_rd_data = mem_rd_addr[7:0] ^ {mem_rd_addr[8], 7'h00};
   // Words the array accepts, in order
   always @(posedge mclk)
      if (mem_wr_valid === 1'b1 && mem_wr_ready)
         got.push_back({mem_wr_addr, mem_wr_data});
   spi_master_model m (
      .mclk(mclk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n)
   );
   spi_eeprom_slave #(.PROG_COUNT(50), .DEPTH(FIFO_DEPTH)) DUT (
      .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
      .so(so), .so_oe(so_oe), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
      .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
      .mem_wr_data(mem_wr_data), .protect_level(protect_level), .busy(busy)
   );
   // Compare and count; an unknown only matches an expected unknown
   task automatic check(input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] act);
      samples_checked++;
      if (act !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t ns: expected %h, got %h", $time, exp, act);
      end
   endtask : check
   // Send txq in one frame, optionally held in byte hold_at, replies to rxq
   task automatic frame(input int hold_at);
      logic [7:0] r;
      rxq = {};
      m.sel();
      foreach (txq[i]) begin
         m.xfer(txq[i], (i == hold_at) ? 4 : -1, r);
         rxq.push_back(r);
      end
      m.desel();
   endtask : frame
   // Status frame; the byte is read twice to see it repeat
   task automatic status(input logic [7:0] exp);
      txq = '{STATUS_READ_CMD, 8'h00, 8'h00};
      frame(-1);
      check({9'h0, exp}, {9'h0, rxq[1]});
      check({9'h0, exp}, {9'h0, rxq[2]});
   endtask : status
   // One-byte command
   task automatic cmd(input logic [7:0] op);
      txq = '{op};
      frame(-1);
   endtask : cmd
   // Bounded wait for the programming cycle to end
   task automatic wait_idle();
      for (int n = 0; n < 2000 && busy !== 1'b0; n++)
         @(posedge mclk);
      check('0, {16'h0, busy});
   endtask : wait_idle
   function automatic logic [7:0] memf(input logic [8:0] a);
      return a[7:0] ^ {a[8], 7'h00};
   endfunction : memf
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // Watchdog well beyond the expected run of some 6600 cycles
   initial begin
      repeat (50000) @(posedge mclk);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      logic [8:0] a;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk);
      check('0, {16'h0, so_oe});
      status(8'h00);
      cmd(SET_WRITE_LATCH_CMD);
      status(8'h02);
      cmd(CLEAR_WRITE_LATCH_CMD);
      status(8'h00);
      // Read across the top of the array, held in mid byte
      txq = '{ARRAY_READ_CMD | 8'h08, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h00};
      frame(3);
      for (int k = 0; k < 4; k++)
         check({9'h0, memf(9'(9'h1FE + k))}, {9'h0, rxq[2 + k]});
      // Unknown opcode: the status code after it must stay unanswered
      txq = '{8'hFF, STATUS_READ_CMD, 8'h00};
      frame(-1);
      check({9'h0, 8'hxx}, {9'h0, rxq[2]});
      txq = '{ARRAY_WRITE_CMD, 8'h10, 8'hAA};
      frame(-1);
      // Nine bytes into a stalled array: wrap in page, ninth refused as full
      cmd(SET_WRITE_LATCH_CMD);
      txq = '{ARRAY_WRITE_CMD | 8'h08, 8'h0E};
      for (int k = 0; k < 9; k++) begin
         txq.push_back(8'h20 + 8'(k));
         if (k < 8)
            exp_q.push_back({7'h43, 2'(2 + k), 8'h20 + 8'(k)});
      end
      frame(-1);
      status(8'hFF);
      txq = '{ARRAY_READ_CMD, 8'h00, 8'h00};
      frame(-1);
      check({9'h0, 8'hxx}, {9'h0, rxq[2]});
      mem_wr_ready <= 1'b1;
      wait_idle();
      status(8'h00);
      // Every protection level against the edges of the ranges
      for (int lv = 0; lv < 4; lv++) begin
         cmd(SET_WRITE_LATCH_CMD);
         txq = '{STATUS_PROGRAM_CMD, {4'h0, 2'(lv), 2'h0}};
         frame(-1);
         wait_idle();
         status({4'h0, 2'(lv), 2'h0});
         for (int j = 0; j < 3; j++) begin
            a = prot_addr[j];
            cmd(SET_WRITE_LATCH_CMD);
            txq = '{ARRAY_WRITE_CMD | {4'h0, a[8], 3'h0}, a[7:0], 8'h50 + 8'(lv)};
            frame(-1);
            wait_idle();
            if (!(lv == 3 || (lv == 2 && a[8]) || (lv == 1 && a[8:7] == 2'b11)))
               exp_q.push_back({a, 8'h50 + 8'(lv)});
         end
      end
      check(WORD_W'(exp_q.size()), WORD_W'(got.size()));
      foreach (exp_q[i])
         check(exp_q[i], got[i]);
      end_of_test();
   end
endmodule : spi_eeprom_slave_test

// *** tb/spi_master_model.sv ***
// Serial bus master model that selects, clocks and holds the slave
`timescale 1ns/1ps
module spi_master_model (
   input wire logic mclk,
   input wire logic so,
   input wire logic so_oe,
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic hold_n
);
   // Deselected and idle from time zero; clock idles low
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
   end
   // Select and give the slave time to see it
   task automatic sel();
      cs_n <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : sel
   // One byte each way; an undriven output reads as x
   task automatic xfer(input logic [7:0] tx, input int hold_bit, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         if (i == hold_bit) begin
            repeat (3) @(posedge mclk);
            hold_n <= 1'b0;
            repeat (6) @(posedge mclk);
            hold_n <= 1'b1;
         end
         si <= tx[i];
         repeat (3) @(posedge mclk);
         rx[i] = so_oe ? so : 1'bx;
         sck <= 1'b1;
         repeat (3) @(posedge mclk);
         sck <= 1'b0;
      end
   endtask : xfer
   // Deselect in the clock low time; the released data line flips
   task automatic desel();
      repeat (3) @(posedge mclk);
      cs_n <= 1'b1;
      si <= ~si;
      repeat (6) @(posedge mclk);
   endtask : desel
endmodule : spi_master_model
